// file: hdl/cbfi_regs.vh
// Holds the register map, field positions, lamp codes and timing counts.
// Assumes inclusion by the bay and top files; a 10 MHz pclk.
`ifndef CBFI_REGS_VH
`define CBFI_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CBFI_CTRL_OFS 12'h000
`define CBFI_LATCH_OFS 12'h004
`define CBFI_ACT_OFS 12'h008
`define CBFI_STAT_OFS 12'h00C
`define CBFI_LAMP_OFS 12'h010
`define CBFI_FLTIN_OFS 12'h014

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define CBFI_CTRL_CAP_BIT 0
`define CBFI_CTRL_RST 32'h00000000
`define CBFI_LATCH_MASK_RST 15'h7FFF

// ----------------------------------------------------------------------
// Fault indices, one bit each in a 15-bit fault vector
// ----------------------------------------------------------------------
`define CBFI_NFAULT 15
`define CBFI_F_CCV 0
`define CBFI_F_DSCH 1
`define CBFI_F_DTIME 2
`define CBFI_F_OVCH 3
`define CBFI_F_TEMP 4
`define CBFI_F_LOBV 5
`define CBFI_F_HICC 6
`define CBFI_F_SD2 7
`define CBFI_F_HIBV 8
`define CBFI_F_CAP 9
`define CBFI_F_SD1 10
`define CBFI_F_CV 11
`define CBFI_F_VCC 12
`define CBFI_F_LOPS 13
`define CBFI_F_LOCC 14

// ----------------------------------------------------------------------
// Lamp codes, bit 3 charger-on, 2 ready, 1 fault, 0 testing
// ----------------------------------------------------------------------
`define CBFI_C_CCV 4'h8
`define CBFI_C_DSCH 4'hC
`define CBFI_C_DTIME 4'hE
`define CBFI_C_OVCH 4'hF
`define CBFI_C_TEMP 4'hD
`define CBFI_C_LOBV 4'hB
`define CBFI_C_HICC 4'hA
`define CBFI_C_SD2 4'h9
`define CBFI_C_HIBV 4'h7
`define CBFI_C_CAP 4'h3
`define CBFI_C_SD1 4'h1
`define CBFI_C_CV 4'h4
`define CBFI_C_VCC 4'h5
`define CBFI_C_LOPS 4'h6
`define CBFI_C_LOCC 4'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CBFI_CLK_HZ 10000000
`define CBFI_ALL_ON_MS 3000
`define CBFI_BEEP_MS 200
`define CBFI_RDY_TST_MS 2000
`define CBFI_CAP_LIMIT_H 8
`define CBFI_FAST_LIMIT_H 4
`define CBFI_MS_CYC (`CBFI_CLK_HZ / 1000)
`define CBFI_ALL_ON_CYC (`CBFI_ALL_ON_MS * `CBFI_MS_CYC)
`define CBFI_BEEP_CYC (`CBFI_BEEP_MS * `CBFI_MS_CYC)
`define CBFI_RDY_TST_CYC (`CBFI_RDY_TST_MS * `CBFI_MS_CYC)
`define CBFI_CAP_LIMIT_S (`CBFI_CAP_LIMIT_H * 3600)
`define CBFI_FAST_LIMIT_S (`CBFI_FAST_LIMIT_H * 3600)

`endif

// file: hdl/cbfi_bay.v
// Holds the indication logic for one charger compartment.
// Assumes synchronised inputs on pclk and a one-millisecond tick.
`timescale 1ns/1ps
`include "cbfi_regs.vh"

module cbfi_bay #(
    parameter ALL_ON_MS = `CBFI_ALL_ON_MS,
    parameter BEEP_MS = `CBFI_BEEP_MS,
    parameter RDY_TST_MS = `CBFI_RDY_TST_MS,
    parameter CAP_LIMIT_S = `CBFI_CAP_LIMIT_S,
    parameter FAST_LIMIT_S = `CBFI_FAST_LIMIT_S
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire ms_tick,
    input wire sec_tick,
    input wire button,
    input wire batt_present,
    input wire capacity_check_mode,
    input wire full_charged,
    input wire cap_ok,
    input wire cap_test_req,
    input wire [14:0] fault_in,
    input wire [14:0] latch_mask,
    output reg [3:0] lamps_r,
    output reg beep_r,
    output reg [14:0] latched_r,
    output reg [14:0] active_r,
    output reg selftest_r,
    output reg cycle_timeout_r
);

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_ALL = 3'h1;
    localparam S_BEEP = 3'h2;
    localparam S_RT = 3'h3;
    localparam S_CHG = 3'h4;
    localparam S_TEST = 3'h5;
    localparam S_READY = 3'h6;
    localparam S_CAPF = 3'h7;

    reg [2:0] st_r;
    reg [2:0] st_nxt;
    reg [15:0] ms_r;
    reg [15:0] sec_r;
    reg btn_d_r;
    reg [14:0] lat_nxt;
    reg [3:0] code;
    reg [3:0] lamp_nxt;
    wire btn_rise;
    wire [14:0] faults;
    wire any_fault;
    integer i;

    assign btn_rise = button & ~btn_d_r;
    // Latched bits hold; other bits follow their input directly.
    assign faults = latched_r | (fault_in & ~latch_mask);
    assign any_fault = |faults;

    always @* begin
        lat_nxt = latched_r | (fault_in & latch_mask);
        if (cycle_timeout_r && st_r == S_CHG) begin
            lat_nxt[`CBFI_F_DTIME] = 1'b1;
        end
    end

    // Lowest index active fault selects the code.
    always @* begin
        code = 4'h0;
        for (i = `CBFI_NFAULT - 1; i >= 0; i = i - 1) begin
            if (faults[i]) begin
                case (i)
                    `CBFI_F_CCV: code = `CBFI_C_CCV;
                    `CBFI_F_DSCH: code = `CBFI_C_DSCH;
                    `CBFI_F_DTIME: code = `CBFI_C_DTIME;
                    `CBFI_F_OVCH: code = `CBFI_C_OVCH;
                    `CBFI_F_TEMP: code = `CBFI_C_TEMP;
                    `CBFI_F_LOBV: code = `CBFI_C_LOBV;
                    `CBFI_F_HIBV: code = `CBFI_C_HIBV;
                    `CBFI_F_HICC: code = `CBFI_C_HICC;
                    `CBFI_F_LOCC: code = `CBFI_C_LOCC;
                    `CBFI_F_SD2: code = `CBFI_C_SD2;
                    `CBFI_F_SD1: code = `CBFI_C_SD1;
                    `CBFI_F_CAP: code = `CBFI_C_CAP;
                    `CBFI_F_CV: code = `CBFI_C_CV;
                    `CBFI_F_VCC: code = `CBFI_C_VCC;
                    `CBFI_F_LOPS: code = `CBFI_C_LOPS;
                    default: code = 4'h0;
                endcase
            end
        end
    end

    always @* begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (btn_rise && !batt_present) begin
                    st_nxt = S_ALL;
                end else if (batt_present) begin
                    st_nxt = S_CHG;
                end
            end
            S_ALL: begin
                if (ms_r >= ALL_ON_MS - 1 && ms_tick) begin
                    st_nxt = S_BEEP;
                end
            end
            S_BEEP: begin
                if (ms_r >= BEEP_MS - 1 && ms_tick) begin
                    st_nxt = S_RT;
                end
            end
            S_RT: begin
                if (ms_r >= RDY_TST_MS - 1 && ms_tick) begin
                    st_nxt = S_IDLE;
                end
            end
            S_CHG: begin
                if (!batt_present) begin
                    st_nxt = S_IDLE;
                end else if (full_charged) begin
                    if (capacity_check_mode) begin
                        st_nxt = S_TEST;
                    end else begin
                        st_nxt = S_READY;
                    end
                end
            end
            S_TEST: begin
                if (!batt_present) begin
                    st_nxt = S_IDLE;
                end else if (cap_ok) begin
                    st_nxt = S_READY;
                end else if (cycle_timeout_r) begin
                    st_nxt = S_CAPF;
                end
            end
            S_READY: begin
                if (!batt_present) begin
                    st_nxt = S_IDLE;
                end else if (cap_test_req && !capacity_check_mode) begin
                    st_nxt = S_TEST;
                end
            end
            S_CAPF: begin
                if (!batt_present) begin
                    st_nxt = S_IDLE;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    always @* begin
        lamp_nxt = 4'h0;
        case (st_r)
            S_ALL: lamp_nxt = 4'hF;
            S_BEEP: lamp_nxt = 4'hF;
            S_RT: lamp_nxt = 4'h5;
            S_CHG: lamp_nxt = 4'h8;
            S_TEST: lamp_nxt = 4'h9;
            S_READY: lamp_nxt = 4'h4;
            S_CAPF: lamp_nxt = 4'h3;
            default: lamp_nxt = 4'h0;
        endcase
        if (any_fault && st_r != S_CAPF) begin
            lamp_nxt = button ? code : 4'h2;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= S_IDLE;
            ms_r <= 16'h0000;
            sec_r <= 16'h0000;
            btn_d_r <= 1'b0;
            lamps_r <= 4'h0;
            beep_r <= 1'b0;
            latched_r <= 15'h0000;
            active_r <= 15'h0000;
            selftest_r <= 1'b0;
            cycle_timeout_r <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            btn_d_r <= button;
            latched_r <= lat_nxt;
            active_r <= faults;
            lamps_r <= lamp_nxt;
            beep_r <= (st_nxt == S_BEEP);
            selftest_r <= (st_nxt == S_ALL) || (st_nxt == S_BEEP) ||
                          (st_nxt == S_RT);
            if (st_nxt != st_r) begin
                ms_r <= 16'h0000;
            end else if (ms_tick) begin
                ms_r <= ms_r + 16'h0001;
            end
            if (st_r == S_IDLE) begin
                sec_r <= 16'h0000;
                cycle_timeout_r <= 1'b0;
            end else if (sec_tick && (st_r == S_CHG || st_r == S_TEST)) begin
                sec_r <= sec_r + 16'h0001;
                if (capacity_check_mode) begin
                    cycle_timeout_r <= (sec_r >= CAP_LIMIT_S - 1);
                end else begin
                    cycle_timeout_r <= (sec_r >= FAST_LIMIT_S - 1);
                end
            end
        end
    end

endmodule

// file: hdl/cbfi_top.v
// Holds four compartments, input synchronisers and the APB register slave.
// Assumes a 10 MHz pclk and pins from outside the clock domain.
`timescale 1ns/1ps
`include "cbfi_regs.vh"

// Functional notes
// - Empty bay button press starts self-test.
// - All lamps, beep, ready+testing, then off.
// - Reliability faults latch until power-on reset.
// - Other faults clear when input drops.
// - Held button shows fault code pattern.
// - Capacity fail shows testing+fault, button ignored.
// - Compliance voltage low shows 1000.
// - Ineffective discharge shows 1100.
// - Discharge impossible shows 1110.
// - Overcharge shows 1111.
// - Temperature fault shows 1101.
// - Battery voltage low 1011, high 0111.
// - Current high 1010, low 0010.
// - Shutdown path two 1001, one 0001.
// - Capacity low shows 0011.
// - Constant voltage fault shows 0100.
// - Logic supply fault shows 0101.
// - Charging supply low shows 0110.
// - Capacity mode tests every recharge.
// - Capacity mode cycle ends within eight hours.
// - Fast mode skips capacity test unless requested.
// - Fast mode cycle ends within four hours.
module cbfi_top #(
    parameter NBAY = 4,
    parameter MS_CYC = `CBFI_MS_CYC,
    parameter ALL_ON_MS = `CBFI_ALL_ON_MS,
    parameter BEEP_MS = `CBFI_BEEP_MS,
    parameter RDY_TST_MS = `CBFI_RDY_TST_MS,
    parameter CAP_LIMIT_S = `CBFI_CAP_LIMIT_S,
    parameter FAST_LIMIT_S = `CBFI_FAST_LIMIT_S
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [3:0] button_pin,
    input wire [3:0] batt_present_pin,
    input wire [3:0] full_charged,
    input wire [3:0] cap_ok,
    input wire [3:0] cap_test_req,
    input wire [59:0] fault_in,
    output wire [15:0] lamps,
    output wire beep
);

    // ------------------------------------------------------------------
    // Registers and timebase
    // ------------------------------------------------------------------
    reg [31:0] ctrl_r;
    reg [14:0] latch_mask_r;
    reg [15:0] div_r;
    reg ms_tick_r;
    reg [9:0] sdiv_r;
    reg sec_tick_r;
    reg [3:0] btn_s1_r;
    reg [3:0] btn_s2_r;
    reg [3:0] btn_s3_r;
    reg [3:0] btn_r;
    reg [3:0] bat_s1_r;
    reg [3:0] bat_s2_r;
    reg [3:0] bat_s3_r;
    reg [3:0] bat_r;
    wire [59:0] active;
    wire [3:0] selftest;
    wire [3:0] timeout;
    wire [3:0] beeps;
    wire wr_en;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite & clk_en;
    assign beep = |beeps;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CBFI_CTRL_RST;
            latch_mask_r <= `CBFI_LATCH_MASK_RST;
            div_r <= 16'h0000;
            ms_tick_r <= 1'b0;
            sdiv_r <= 10'h000;
            sec_tick_r <= 1'b0;
            btn_s1_r <= 4'h0;
            btn_s2_r <= 4'h0;
            btn_s3_r <= 4'h0;
            btn_r <= 4'h0;
            bat_s1_r <= 4'h0;
            bat_s2_r <= 4'h0;
            bat_s3_r <= 4'h0;
            bat_r <= 4'h0;
        end else if (clk_en) begin
            if (wr_en && paddr == `CBFI_CTRL_OFS) begin
                ctrl_r <= {31'h00000000, pwdata[`CBFI_CTRL_CAP_BIT]};
            end
            if (wr_en && paddr == `CBFI_LATCH_OFS) begin
                latch_mask_r <= pwdata[14:0];
            end
            ms_tick_r <= (div_r == MS_CYC - 1);
            if (div_r == MS_CYC - 1) begin
                div_r <= 16'h0000;
            end else begin
                div_r <= div_r + 16'h0001;
            end
            sec_tick_r <= ms_tick_r && (sdiv_r == 10'h3E7);
            if (ms_tick_r) begin
                sdiv_r <= (sdiv_r == 10'h3E7) ? 10'h000 :
                          sdiv_r + 10'h001;
            end
            btn_s1_r <= button_pin;
            btn_s2_r <= btn_s1_r;
            btn_s3_r <= btn_s2_r;
            btn_r <= (btn_s2_r == btn_s3_r) ? btn_s3_r : btn_r;
            bat_s1_r <= batt_present_pin;
            bat_s2_r <= bat_s1_r;
            bat_s3_r <= bat_s2_r;
            bat_r <= (bat_s2_r == bat_s3_r) ? bat_s3_r : bat_r;
        end
    end

    // ------------------------------------------------------------------
    // Read mux of the register map; unmapped offsets read as zero.
    // ------------------------------------------------------------------
    always @* begin
        prdata = 32'h00000000;
        case (paddr)
            `CBFI_CTRL_OFS: prdata = ctrl_r;
            `CBFI_LATCH_OFS: prdata = {17'h00000, latch_mask_r};
            `CBFI_ACT_OFS: prdata = {2'b00, active[29:15], 15'h0000} |
                                    {17'h00000, active[14:0]};
            `CBFI_STAT_OFS: prdata = {24'h000000, timeout, selftest};
            `CBFI_LAMP_OFS: prdata = {16'h0000, lamps};
            `CBFI_FLTIN_OFS: prdata = {2'b00, active[59:45], active[44:30]};
            default: prdata = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // Compartments
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NBAY; g = g + 1) begin : bay
            cbfi_bay #(
                .ALL_ON_MS(ALL_ON_MS),
                .BEEP_MS(BEEP_MS),
                .RDY_TST_MS(RDY_TST_MS),
                .CAP_LIMIT_S(CAP_LIMIT_S),
                .FAST_LIMIT_S(FAST_LIMIT_S)
            ) u_bay (
                .pclk(pclk),
                .presetn(presetn),
                .clk_en(clk_en),
                .ms_tick(ms_tick_r),
                .sec_tick(sec_tick_r),
                .button(btn_r[g]),
                .batt_present(bat_r[g]),
                .capacity_check_mode(ctrl_r[`CBFI_CTRL_CAP_BIT]),
                .full_charged(full_charged[g]),
                .cap_ok(cap_ok[g]),
                .cap_test_req(cap_test_req[g]),
                .fault_in(fault_in[g*15 +: 15]),
                .latch_mask(latch_mask_r),
                .lamps_r(lamps[g*4 +: 4]),
                .beep_r(beeps[g]),
                .latched_r(),
                .active_r(active[g*15 +: 15]),
                .selftest_r(selftest[g]),
                .cycle_timeout_r(timeout[g])
            );
        end
    endgenerate

endmodule

// file: verification/cbfi_top_assertions.sv
// Holds concurrent checks on the charger bay indicator top.
// Assumes binding to cbfi_top run with shortened timing parameters.
`timescale 1ns/1ps
module cbfi_top_assertions #(
    parameter MS_CYC = 10,
    parameter BEEP_MS = 2
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [3:0] button_pin,
    input wire [3:0] batt_present_pin,
    input wire [3:0] full_charged,
    input wire [3:0] cap_ok,
    input wire [3:0] cap_test_req,
    input wire [59:0] fault_in,
    input wire [15:0] lamps,
    input wire beep
);
    localparam int LO = (BEEP_MS - 1) * MS_CYC;
    localparam int HI = BEEP_MS * MS_CYC + 1;
    int cnt;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Counts the cycles of the current beep.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
        end else if (beep) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
    end
    sequence idle0;
        (!batt_present_pin[0] && !button_pin[0] && lamps[3:0] == 4'h0)[*4];
    endsequence
    sequence hold0;
        (!batt_present_pin[0] && button_pin[0] && fault_in[14:0] == 15'h0)[*8];
    endsequence
    sequence capfail0;
        lamps[3:0] == 4'h3 && !button_pin[0] && batt_present_pin[0]
            && fault_in[14:0] == 15'h0;
    endsequence
    apb_ready_a: assert property (psel && penable |-> pready && !pslverr)
        else $error("access not completed cleanly");
    unmapped_read_a: assert property (psel && !pwrite && paddr == 12'h018
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    selftest_start_a: assert property (idle0 ##1 hold0 |-> lamps[3:0] == 4'hF)
        else $error("self-test did not light all");
    beep_all_on_a: assert property (beep |-> lamps[3:0] == 4'hF
        || lamps[7:4] == 4'hF || lamps[11:8] == 4'hF || lamps[15:12] == 4'hF)
        else $error("beep without all lamps");
    beep_length_a: assert property ($fell(beep) |-> cnt >= LO && cnt <= HI)
        else $error("beep length wrong");
    beep_then_rt_a: assert property ($fell(beep) && $past(lamps[3:0]) == 4'hF
        |-> ##[0:2] lamps[3:0] == 4'h5)
        else $error("no ready and testing after beep");
    fault_lamp_a: assert property ((batt_present_pin[0] && !button_pin[0]
        && fault_in[14:0] != 15'h0)[*8] |-> lamps[1])
        else $error("fault lamp dark");
    code_first_a: assert property ((batt_present_pin[0] && button_pin[0]
        && fault_in[0])[*8] |-> lamps[3:0] == 4'h8 || lamps[3:0] == 4'h3)
        else $error("wrong code for first fault");
    code_last_a: assert property ((batt_present_pin[0] && button_pin[0]
        && fault_in[14:0] == 15'h4000)[*8] |-> lamps[3:0] inside {4'h2, 4'h3})
        else $error("wrong code for low current");
    cap_fail_hold_a: assert property (capfail0 ##1 (button_pin[0]
        && batt_present_pin[0] && fault_in[14:0] == 15'h0)[*8]
        |-> lamps[3:0] == 4'h3) else $error("fail pattern changed");
endmodule

bind cbfi_top cbfi_top_assertions #(.MS_CYC(MS_CYC), .BEEP_MS(BEEP_MS)) chk_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .button_pin(button_pin), .batt_present_pin(batt_present_pin),
    .full_charged(full_charged), .cap_ok(cap_ok),
    .cap_test_req(cap_test_req), .fault_in(fault_in), .lamps(lamps),
    .beep(beep)
);

// file: verification/cbfi_operator.sv
// Holds the operator model: test buttons, battery slots and lamp watching.
// Assumes calls from the bench right after a rising pclk edge.
`timescale 1ns/1ps
module cbfi_operator (
    input wire pclk,
    input wire [15:0] lamps,
    output reg [3:0] button_pin,
    output reg [3:0] batt_present_pin
);
    initial begin
        button_pin = 4'h0;
        batt_present_pin = 4'h0;
    end
    task clear;
        button_pin <= 4'h0;
        batt_present_pin <= 4'h0;
        @(posedge pclk);
    endtask
    // Holds or lets go the button of one bay.
    task push(input int g, input logic v);
        button_pin[g] <= v;
        @(posedge pclk);
    endtask
    task slot(input int g, input logic v);
        batt_present_pin[g] <= v;
        @(posedge pclk);
    endtask
    // Watches one bay until its lamps show v or n cycles pass.
    task look(input int g, input logic [3:0] v, input int n,
              output logic [3:0] seen);
        seen = lamps[g*4+:4];
        while (seen !== v && n > 0) begin
            @(posedge pclk);
            seen = lamps[g*4+:4];
            n--;
        end
    endtask
endmodule

// file: verification/cbfi_top_test.sv
// Holds the self-checking bench for the charger bay indicator top.
// Assumes the operator model and the bound checker; shortened timing.
`timescale 1ns/1ps
module cbfi_top_test;
    localparam int MS = 10;
    localparam int CAPS = 3;
    localparam int FASTS = 2;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, beep;
    logic [3:0] full_charged = 4'h0, cap_ok = 4'h0, cap_test_req = 4'h0, s;
    logic [59:0] fault_in = 60'h0;
    logic [15:0] lamps;
    wire [3:0] button_pin, batt_present_pin;
    int err_count = 0, num_checks = 0, cyc = 0, i, k, m, lim;
    logic [3:0] code [15] = '{4'h8, 4'hC, 4'hE, 4'hF, 4'hD, 4'hB, 4'hA, 4'h9,
                              4'h7, 4'h3, 4'h1, 4'h4, 4'h5, 4'h6, 4'h2};
    cbfi_top #(.MS_CYC(MS), .ALL_ON_MS(3), .BEEP_MS(2), .RDY_TST_MS(2),
               .CAP_LIMIT_S(CAPS), .FAST_LIMIT_S(FASTS)) uut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .button_pin(button_pin), .batt_present_pin(batt_present_pin),
        .full_charged(full_charged), .cap_ok(cap_ok),
        .cap_test_req(cap_test_req), .fault_in(fault_in), .lamps(lamps),
        .beep(beep));
    cbfi_operator op (.pclk(pclk), .lamps(lamps), .button_pin(button_pin),
                      .batt_present_pin(batt_present_pin));
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            final_report();
        end
    end
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
        num_checks++;
        if (seen !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, seen);
            err_count++;
        end
    endtask
    // One APB transfer; read data lands in q.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) err_count++;
        q = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(0, a, 32'h0);
        chk(n, q, e);
    endtask
    task rst;
        presetn <= 0;
        fault_in <= 60'h0;
        full_charged <= 4'h0;
        cap_ok <= 4'h0;
        cap_test_req <= 4'h0;
        op.clear();
        repeat (19) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
    endtask
    initial begin
        rst();
        rd(12'h000, 32'h0, "ctrl");
        rd(12'h004, 32'h7FFF, "mask");
        apb(1, 12'h018, 32'hFFFFFFFF);
        rd(12'h018, 32'h0, "unmapped");
        clk_en <= 0;
        apb(1, 12'h000, 32'h1);
        clk_en <= 1;
        rd(12'h000, 32'h0, "frozen write");
        apb(1, 12'h000, 32'hFFFFFFFF);
        rd(12'h000, 32'h1, "ctrl");
        apb(1, 12'h000, 32'h0);
        for (k = 0; k < 4; k++) begin
            op.push(k, 1);
            op.look(k, 4'hF, 20, s);
            chk("all on", s, 4'hF);
            chk("other bays", lamps & ~(16'hF << (4 * k)), 32'h0);
            i = 0;
            while (beep !== 1'b1 && i < 80) begin
                @(posedge pclk);
                i++;
            end
            chk("beep", beep, 32'h1);
            op.push(k, 0);
            op.look(k, 4'h5, 60, s);
            chk("ready testing", {beep, s}, 32'h5);
            op.look(k, 4'h0, 60, s);
            chk("off", s, 32'h0);
        end
        op.slot(0, 1);
        repeat (5) @(posedge pclk);
        op.push(0, 1);
        i = 0;
        repeat (100) begin
            @(posedge pclk);
            if (beep === 1'b1) i++;
        end
        chk("no self-test", i, 32'h0);
        chk("charging", lamps[3:0], 32'h8);
        op.push(0, 0);
        apb(1, 12'h004, 32'h0);
        for (k = 0; k < 15; k++) begin
            fault_in[k] <= 1;
            op.look(0, 4'h2, 20, s);
            chk("fault lamp", s, 32'h2);
            repeat (8) @(posedge pclk);
            rd(12'h008, 32'h1 << k, "active");
            op.push(0, 1);
            op.look(0, code[k], 20, s);
            chk("code", s, code[k]);
            repeat (8) @(posedge pclk);
            op.push(0, 0);
            fault_in[k] <= 0;
            op.look(0, 4'h8, 20, s);
            chk("cleared", s, 32'h8);
        end
        rst();
        op.slot(3, 1);
        fault_in[49] <= 1;
        repeat (10) @(posedge pclk);
        fault_in[49] <= 0;
        repeat (10) @(posedge pclk);
        rd(12'h014, 32'h80000, "latched");
        rd(12'h008, 32'h0, "bay0 clean");
        chk("latched lamp", lamps[15:12], 32'h2);
        rst();
        rd(12'h014, 32'h0, "after reset");
        for (m = 1; m >= 0; m--) begin
            rst();
            apb(1, 12'h000, 32'h1);
            op.slot(0, 1);
            cap_ok[0] <= m;
            full_charged[0] <= 1;
            op.look(0, m ? 4'h4 : 4'h3, (CAPS + 1) * 1000 * MS, s);
            chk("capacity result", s, m ? 32'h4 : 32'h3);
        end
        op.push(0, 1);
        repeat (20) @(posedge pclk);
        chk("fail held", lamps[3:0], 32'h3);
        rst();
        op.slot(0, 1);
        full_charged[0] <= 1;
        op.look(0, 4'h4, 2000, s);
        chk("fast ready", s, 32'h4);
        cap_test_req[0] <= 1;
        op.look(0, 4'h9, 2000, s);
        chk("manual test", s, 32'h9);
        for (m = 0; m < 2; m++) begin
            rst();
            apb(1, 12'h000, m);
            op.slot(0, 1);
            lim = m ? CAPS : FASTS;
            repeat ((lim - 1) * 1000 * MS - 1000) @(posedge pclk);
            rd(12'h00C, 32'h0, "early");
            q = 32'h0;
            i = 0;
            while (q[4] !== 1'b1 && i < 5000) begin
                apb(0, 12'h00C, 32'h0);
                i++;
            end
            chk("timeout", q[4], 32'h1);
            rd(12'h008, 32'h4, "time fault");
        end
        final_report();
    end
endmodule
